//--- include/uioc_pkg.sv
// uioc_pkg: register map, field layout, timing counts and carrier types
// assumes a 50 MHz device clock and a 32-bit APB register port
package uioc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] MODE_OFS = 12'h00C;
	localparam logic [ADDR_W-1:0] IRQ_CFG_OFS = 12'h010;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h014;

	// operating_mode_control fields
	localparam int MODE_PULLUP_BIT = 0;
	localparam int MODE_SUSP_PMODE_BIT = 1;
	localparam int MODE_WAKE_RD_BIT = 2;
	localparam int MODE_GLINT_BIT = 3;
	localparam int MODE_VBUS_BIT = 8;
	localparam int MODE_STORE_W = 4;
	localparam logic [MODE_STORE_W-1:0] MODE_RST = 4'h0;

	// interrupt_output_config fields
	localparam int CFG_W = 8;
	localparam int CFG_POL_BIT = 0;
	localparam int CFG_LVL_BIT = 1;
	localparam int CFG_SEL_LSB = 2;
	localparam int CFG_SEL_W = 6;
	localparam logic [CFG_W-1:0] IRQ_CFG_RST = 8'hFC;

	// status fields
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_SUSP_BIT = 1;
	localparam int STAT_IRQ_BIT = 2;
	localparam int STAT_SPIN_BIT = 3;

	// timing
	localparam int CLK_KHZ = 50000;
	localparam int IRQ_PULSE_NS = 60;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_KHZ + 999999) / 1000000;
	localparam int SUSP_PULSE_MS = 1;
	localparam int SUSP_PULSE_CYC = SUSP_PULSE_MS * CLK_KHZ;
	localparam int IDLE_MS = 3;
	localparam int IDLE_CYC = IDLE_MS * CLK_KHZ;

	// handshake events from the serial engine
	typedef enum logic [1:0] {
		UIOC_EP_OUT = 2'h0,
		UIOC_EP_IN = 2'h1,
		UIOC_EP_CTL = 2'h2
	} uioc_ep_t;
	typedef enum logic [1:0] {
		UIOC_HS_ACK = 2'h0,
		UIOC_HS_NAK = 2'h1,
		UIOC_HS_NYET = 2'h2
	} uioc_hs_kind_t;
	typedef struct packed {
		logic valid;
		uioc_ep_t ep;
		uioc_hs_kind_t kind;
	} uioc_hs_evt_t;

	localparam int EP_CLASSES = 3;
	localparam logic [1:0] SEL_ALL = 2'h0;
	localparam logic [1:0] SEL_ACK_ONLY = 2'h1;
	localparam int SEL_FIRST_NAK_BIT = 1;
endpackage

//--- hw/uioc_pulse_timer.sv
// uioc_pulse_timer: one-shot of a fixed number of clock cycles
// assumes start pulses from the same clock domain; starts while active are ignored
`timescale 1ns/100ps
module uioc_pulse_timer #(
	parameter int LEN_CYC = 3
) (
	input wire logic i_clock, // device clock
	input wire logic i_rstn, // async reset, active low
	input wire logic i_start, // start pulse
	output logic o_active // high for LEN_CYC cycles after start
);
	localparam int CNT_W = $clog2(LEN_CYC + 1);
	localparam logic [CNT_W-1:0] LEN = CNT_W'(LEN_CYC);

	generate
		if (LEN_CYC < 1) begin : g_bad_len
			$error("pulse length must be at least one cycle");
		end
	endgenerate

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	wire busy_w = (cnt_q != '0);

	assign cnt_d = busy_w ? cnt_q - CNT_W'(1) : (i_start ? LEN : '0);
	assign o_active = busy_w;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- hw/uioc_hs_filter.sv
// uioc_hs_filter: decides which handshakes raise an interrupt event
// assumes one handshake report per cycle at most from the serial engine
`timescale 1ns/100ps
module uioc_hs_filter
	import uioc_pkg::*;
(
	input wire logic i_clock, // device clock
	input wire logic i_rstn, // async reset, active low
	input uioc_hs_evt_t i_evt, // handshake report
	input wire logic i_setup_ack, // setup token acknowledged
	input wire logic [CFG_SEL_W-1:0] i_sel, // out, in, ep0 selection fields
	output logic o_irq // one-cycle interrupt event
);
	logic [EP_CLASSES-1:0] armed_q;
	logic [EP_CLASSES-1:0] pass_w;
	logic irq_q;

	genvar c;
	generate
		for (c = 0; c < EP_CLASSES; c++) begin : g_class
			wire [1:0] sel_w = i_sel[2*c+1:2*c];
			wire mine_w = i_evt.valid && (i_evt.ep == uioc_ep_t'(c));
			wire nak_w = mine_w && (i_evt.kind == UIOC_HS_NAK);
			wire nak_ok_w = sel_w[SEL_FIRST_NAK_BIT] ? armed_q[c] : (sel_w == SEL_ALL);
			assign pass_w[c] = mine_w && ((i_evt.kind == UIOC_HS_ACK) ||
				(i_evt.kind == UIOC_HS_NYET && c == int'(UIOC_EP_OUT)) ||
				(i_evt.kind == UIOC_HS_NAK && nak_ok_w));
			always_ff @(posedge i_clock or negedge i_rstn) begin
				if (!i_rstn) begin
					armed_q[c] <= 1'b0;
				end else if (i_setup_ack) begin
					armed_q[c] <= 1'b1;
				end else if (nak_w) begin
					armed_q[c] <= 1'b0;
				end
			end
			AST_NAK_ONCE: assert property (@(posedge i_clock) disable iff (!i_rstn)
				(nak_w && sel_w[SEL_FIRST_NAK_BIT] && !armed_q[c] && !i_setup_ack) |=> !o_irq)
				else $error("repeated NAK raised an interrupt");
		end
	endgenerate

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |pass_w;
		end
	end
	assign o_irq = irq_q;
endmodule

//--- hw/uioc_ctrl.sv
// uioc_ctrl: interrupt pin, suspend pin and pull-up control of a USB peripheral
// assumes APB master on i_clock; serial engine and interrupt status logic are outside
//
// Contract
// - global enable lets unmasked interrupts reach pin
// - global enable off keeps pin inactive
// - level mode: enabling with pending asserts pin
// - pulse mode: events before enabling give no pulse
// - wake bit: register read in suspend wakes
// - suspend pin mode 0: high while suspended
// - suspend pin mode 1: 1 ms pulse on wake
// - pull-up connect bit switches D+ pull-up
// - pull-up follows bit regardless of VBUS
// - no pull-up or VBUS: suspend irq after 3 ms
// - ep0 handshake irqs follow bits 7:6
// - IN endpoint handshake irqs follow bits 5:4
// - OUT endpoint handshake irqs follow bits 3:2
// - bit 1 selects level or 60 ns pulse
// - bit 0 selects active low or high
// - bus reset sets selections, keeps mode, polarity
// - selection codes: all, ACK only, first NAK
// - first NAK is first after setup ACK
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module uioc_ctrl
	import uioc_pkg::*;
#(
	parameter int SUSP_PULSE_CYCLES = SUSP_PULSE_CYC,
	parameter int IDLE_CYCLES = IDLE_CYC
) (
	input wire logic i_clock, // 50 MHz device clock
	input wire logic i_rstn, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [ADDR_W-1:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	input wire logic [3:0] i_pstrb, // apb byte strobes
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	input wire logic i_bus_reset, // usb bus reset pulse
	input wire logic i_irq_pending, // unmasked interrupt pending, level
	input wire logic i_irq_event, // new unmasked interrupt event, pulse
	input uioc_hs_evt_t i_hs_evt, // handshake report
	input wire logic i_setup_ack, // setup token acknowledged
	input wire logic i_suspended, // device in suspend state
	input wire logic i_vbus, // vbus present
	input wire logic i_bus_activity, // usb bus activity seen
	output logic o_irq_pin, // interrupt pin
	output logic o_suspend_pin, // suspend indicator pin
	output logic o_pullup_source_pin, // D+ pull-up enable
	output logic o_hs_irq, // handshake interrupt event
	output logic o_suspend_irq, // idle-bus suspend interrupt event
	output logic o_wake_req // clock restart request
);
	localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);

	generate
		if (IDLE_CYCLES < 2 || SUSP_PULSE_CYCLES < 1) begin : g_bad_par
			$error("timing parameters too small");
		end
	endgenerate

	logic [MODE_STORE_W-1:0] mode_q, mode_d;
	logic [CFG_W-1:0] cfg_q, cfg_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pslverr_q, pslverr_d;
	logic irq_pin_q, irq_pin_d;
	logic spin_q, spin_d;
	logic pullup_q, susp_q, wake_q, sirq_q;
	logic [IDLE_W-1:0] idle_q, idle_d;
	logic irq_pulse_w, spin_pulse_w;

	// apb slave: answer in the second access cycle
	wire setup_w = i_psel && !i_penable;
	wire access_w = i_psel && i_penable && pready_q;
	wire wr_w = access_w && i_pwrite;
	wire rd_w = access_w && !i_pwrite;
	wire hit_mode_w = (i_paddr == MODE_OFS);
	wire hit_cfg_w = (i_paddr == IRQ_CFG_OFS);
	wire hit_stat_w = (i_paddr == STATUS_OFS);
	wire hit_w = hit_mode_w || hit_cfg_w || hit_stat_w;
	wire lane0_w = i_pstrb[0];

	wire glint_w = mode_q[MODE_GLINT_BIT];
	wire wake_en_w = mode_q[MODE_WAKE_RD_BIT];
	wire spmode_w = mode_q[MODE_SUSP_PMODE_BIT];
	wire pullup_w = mode_q[MODE_PULLUP_BIT];
	wire pol_w = cfg_q[CFG_POL_BIT];
	wire lvl_w = cfg_q[CFG_LVL_BIT];

	// register writes; bus reset has priority over a write in the same cycle
	always_comb begin
		mode_d = mode_q;
		cfg_d = cfg_q;
		if (wr_w && lane0_w && hit_mode_w) begin
			mode_d = i_pwdata[MODE_STORE_W-1:0];
		end
		if (wr_w && lane0_w && hit_cfg_w) begin
			cfg_d = i_pwdata[CFG_W-1:0];
		end
		if (i_bus_reset) begin
			mode_d = mode_q;
			mode_d[MODE_WAKE_RD_BIT] = 1'b0;
			cfg_d[CFG_LVL_BIT:CFG_POL_BIT] = cfg_q[CFG_LVL_BIT:CFG_POL_BIT];
			cfg_d[CFG_SEL_LSB +: CFG_SEL_W] = '1;
		end
	end

	always_comb begin
		prdata_d = '0;
		if (hit_mode_w) begin
			prdata_d[MODE_STORE_W-1:0] = mode_q;
			prdata_d[MODE_VBUS_BIT] = i_vbus;
		end else if (hit_cfg_w) begin
			prdata_d[CFG_W-1:0] = cfg_q;
		end else if (hit_stat_w) begin
			prdata_d[STAT_PEND_BIT] = i_irq_pending;
			prdata_d[STAT_SUSP_BIT] = susp_q;
			prdata_d[STAT_IRQ_BIT] = (irq_pin_q == pol_w);
			prdata_d[STAT_SPIN_BIT] = spin_q;
		end
	end

	assign pslverr_d = setup_w ? !hit_w : (access_w ? 1'b0 : pslverr_q);

	// interrupt pin
	wire pulse_go_w = glint_w && lvl_w && i_irq_event && !irq_pulse_w;
	wire irq_act_w = lvl_w ? (glint_w && irq_pulse_w) : (glint_w && i_irq_pending);
	assign irq_pin_d = pol_w ? irq_act_w : !irq_act_w;

	uioc_pulse_timer #(
		.LEN_CYC(IRQ_PULSE_CYC)
	) u_irq_pulse (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_start(pulse_go_w),
		.o_active(irq_pulse_w)
	);

	// suspend pin
	wire wake_edge_w = susp_q && !i_suspended;
	assign spin_d = spmode_w ? spin_pulse_w : susp_q;

	uioc_pulse_timer #(
		.LEN_CYC(SUSP_PULSE_CYCLES)
	) u_spin_pulse (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_start(wake_edge_w && spmode_w),
		.o_active(spin_pulse_w)
	);

	// length of the running suspend pin pulse, read only by AST_SPIN_LEN
	localparam int SPIN_W = $clog2(SUSP_PULSE_CYCLES + 1);
	logic [SPIN_W-1:0] spin_len_q, spin_len_d;
	assign spin_len_d = spin_pulse_w ? spin_len_q + SPIN_W'(1) : '0;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			spin_len_q <= '0;
		end else begin
			spin_len_q <= spin_len_d;
		end
	end

	// idle bus timer
	wire idle_cond_w = (!pullup_w || !i_vbus) && !i_bus_activity;
	wire idle_fire_w = idle_cond_w && (idle_q == IDLE_LAST);
	assign idle_d = !idle_cond_w ? '0 : ((idle_q == IDLE_W'(IDLE_CYCLES)) ? idle_q : idle_q + IDLE_W'(1));

	uioc_hs_filter u_hs_filter (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_evt(i_hs_evt),
		.i_setup_ack(i_setup_ack),
		.i_sel(cfg_q[CFG_SEL_LSB +: CFG_SEL_W]),
		.o_irq(o_hs_irq)
	);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_q <= MODE_RST;
			cfg_q <= IRQ_CFG_RST;
		end else begin
			mode_q <= mode_d;
			cfg_q <= cfg_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= setup_w ? prdata_d : prdata_q;
			pready_q <= i_psel && i_penable && !pready_q;
			pslverr_q <= pslverr_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_pin_q <= 1'b1;
			spin_q <= 1'b0;
			pullup_q <= 1'b0;
			susp_q <= 1'b0;
			wake_q <= 1'b0;
			sirq_q <= 1'b0;
			idle_q <= '0;
		end else begin
			irq_pin_q <= irq_pin_d;
			spin_q <= spin_d;
			pullup_q <= pullup_w;
			susp_q <= i_suspended;
			wake_q <= rd_w && hit_w && wake_en_w && susp_q;
			sirq_q <= idle_fire_w;
			idle_q <= idle_d;
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_irq_pin = irq_pin_q;
	assign o_suspend_pin = spin_q;
	assign o_pullup_source_pin = pullup_q;
	assign o_suspend_irq = sirq_q;
	assign o_wake_req = wake_q;

	AST_LVL_NOW: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!lvl_w && glint_w && i_irq_pending) |=> (o_irq_pin == $past(pol_w)))
		else $error("level interrupt not asserted");
	AST_GATE_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!glint_w |=> (o_irq_pin != $past(pol_w)))
		else $error("interrupt pin active while globally disabled");
	AST_PULSE_LEN: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(irq_pulse_w) |-> irq_pulse_w[*3] ##1 !irq_pulse_w)
		else $error("interrupt pulse not three cycles");
	AST_OLD_EVT: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(lvl_w && !glint_w && !irq_pulse_w) |=> !irq_pulse_w)
		else $error("pulse from event before global enable");
	AST_SUSP_LVL: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!spmode_w && $past(!spmode_w)) |=> (o_suspend_pin == $past(i_suspended, 2)))
		else $error("suspend pin does not follow suspend state");
	AST_PULLUP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(pullup_w) |=> o_pullup_source_pin ##1 (o_pullup_source_pin || !$past(pullup_w)))
		else $error("pull-up not connected");
	AST_BUS_RESET: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_bus_reset |=> (cfg_q[CFG_SEL_LSB +: CFG_SEL_W] == '1) &&
		(cfg_q[CFG_LVL_BIT:CFG_POL_BIT] == $past(cfg_q[CFG_LVL_BIT:CFG_POL_BIT])))
		else $error("bus reset did not restore selections");
	AST_WAKE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(rd_w && hit_w && wake_en_w && susp_q) |=> o_wake_req)
		else $error("register read did not wake");
	AST_IDLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_suspend_irq |-> ($past(idle_q) == IDLE_LAST) && $past(idle_cond_w))
		else $error("suspend interrupt without full idle time");
	AST_LVL_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!lvl_w && !i_irq_pending) |=> (o_irq_pin != $past(pol_w)))
		else $error("level interrupt held without pending source");
	AST_PULSE_GO: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(lvl_w && glint_w && i_irq_event && !irq_pulse_w) |=> irq_pulse_w ##1
		((o_irq_pin == $past(pol_w)) || !$past(glint_w)))
		else $error("interrupt event gave no pulse");
	AST_POL_HIGH: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!lvl_w && glint_w && i_irq_pending && pol_w) |=> o_irq_pin)
		else $error("active high interrupt pin not high");
	AST_POL_LOW: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!lvl_w && glint_w && i_irq_pending && !pol_w) |=> !o_irq_pin)
		else $error("active low interrupt pin not low");
	AST_CFG_WRITE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(wr_w && lane0_w && hit_cfg_w && !i_bus_reset) |=> (cfg_q == $past(i_pwdata[CFG_W-1:0])))
		else $error("configuration write lost");
	AST_CFG_KEEP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!i_bus_reset && !(wr_w && lane0_w && hit_cfg_w)) |=> $stable(cfg_q))
		else $error("configuration changed without write or bus reset");
	AST_MODE_KEEP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!i_bus_reset && !(wr_w && lane0_w && hit_mode_w)) |=> $stable(mode_q))
		else $error("mode changed without write or bus reset");
	AST_WAKE_ONLY: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_wake_req |-> ($past(wake_en_w) && $past(susp_q)))
		else $error("wake request without enabled suspended read");
	AST_SPIN_QUIET: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(spmode_w && !spin_pulse_w) |=> !o_suspend_pin)
		else $error("suspend pin high outside wake pulse");
	AST_SPIN_START: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(spmode_w && susp_q && !i_suspended && !spin_pulse_w) |=> spin_pulse_w ##1
		(o_suspend_pin || !$past(spmode_w)))
		else $error("wake from suspend gave no pulse");
	AST_SPIN_LEN: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$fell(spin_pulse_w) |-> (spin_len_q == SPIN_W'(SUSP_PULSE_CYCLES)))
		else $error("suspend pin pulse has wrong length");
	AST_PULLUP_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!pullup_w |=> !o_pullup_source_pin)
		else $error("pull-up still connected");
	AST_PULLUP_ON: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(pullup_w && !i_vbus) |=> o_pullup_source_pin)
		else $error("pull-up dropped without bus power");
	AST_NO_IDLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(pullup_w && i_vbus) |=> !o_suspend_irq)
		else $error("suspend interrupt while connected and powered");
	AST_IDLE_QUIET: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_bus_activity |=> !o_suspend_irq)
		else $error("suspend interrupt during bus activity");
endmodule

//--- dv/uioc_sie_model.sv
// uioc_sie_model: serial engine stand-in that reports handshakes and setup acks
// assumes the caller enters its tasks from one process on the device clock
`timescale 1ns/100ps
module uioc_sie_model
	import uioc_pkg::*;
(
	input wire logic i_clock, // device clock
	output uioc_hs_evt_t o_hs_evt, // handshake report
	output logic o_setup_ack // setup token acknowledged
);
	initial begin
		o_hs_evt = '0;
		o_setup_ack = 1'h0;
	end
	task send(input uioc_ep_t ep, input uioc_hs_kind_t kind);
		@(posedge i_clock);
		o_hs_evt <= '{1'h1, ep, kind};
		@(posedge i_clock);
		// idle report carries a scrambled payload so stale fields are never trusted
		o_hs_evt <= '{1'h0, uioc_ep_t'(~ep), uioc_hs_kind_t'(~kind)};
	endtask
	task setup();
		@(posedge i_clock);
		o_setup_ack <= 1'h1;
		@(posedge i_clock);
		o_setup_ack <= 1'h0;
	endtask
endmodule

//--- dv/testbench.sv
// testbench: register, interrupt pin, handshake, pull-up and suspend pin checks
// assumes uioc_ctrl with shortened suspend pulse and idle counts
`timescale 1ns/100ps
module testbench
	import uioc_pkg::*;
;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, last_err, pol;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic bus_rst, pend, evt, susp, vbus, act, irq_pin, spin, pu, hs_irq, s_irq, wake, setup;
	uioc_hs_evt_t hs;
	int fails, n_compared, cyc, n_irq, n_hs, n_sirq, n_wake, n_spin, ex;
	uioc_ctrl #(.SUSP_PULSE_CYCLES(8), .IDLE_CYCLES(20)) u_dut (.i_clock(clk), .i_rstn(rstn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_bus_reset(bus_rst), .i_irq_pending(pend), .i_irq_event(evt), .i_hs_evt(hs),
		.i_setup_ack(setup), .i_suspended(susp), .i_vbus(vbus), .i_bus_activity(act),
		.o_irq_pin(irq_pin), .o_suspend_pin(spin), .o_pullup_source_pin(pu), .o_hs_irq(hs_irq),
		.o_suspend_irq(s_irq), .o_wake_req(wake));
	uioc_sie_model u_sie (.i_clock(clk), .o_hs_evt(hs), .o_setup_ack(setup));
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(negedge clk) begin
		n_irq += (irq_pin === pol);
		n_hs += (hs_irq === 1'h1);
		n_sirq += (s_irq === 1'h1);
		n_wake += (wake === 1'h1);
		n_spin += (spin === 1'h1);
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			test_done();
		end
	end
	task test_done();
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rdv, exp);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task clr();
		{n_irq, n_hs, n_sirq, n_wake, n_spin} = '0;
	endtask
	task pulse_evt();
		@(posedge clk);
		evt <= 1'h1;
		@(posedge clk);
		evt <= 1'h0;
	endtask
	initial begin
		{rstn, psel, penable, pwrite, bus_rst, pend, evt, susp, vbus, pol} = '0;
		act = 1'h1;
		paddr = 12'h0;
		pwdata = 32'h0;
		{fails, n_compared, cyc} = '0;
		clr();
		tick(12);
		rstn <= 1'h1;
		rd(IRQ_CFG_OFS, 32'h0000_00FC);
		rd(MODE_OFS, 32'h0);
		rd(12'h020, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		pend <= 1'h1;
		tick(6);
		chk({31'h0, irq_pin}, 32'h1);
		wr(MODE_OFS, 32'h8);
		tick(2);
		chk({31'h0, irq_pin}, 32'h0);
		wr(IRQ_CFG_OFS, 32'hFD);
		tick(3);
		chk({31'h0, irq_pin}, 32'h1);
		pend <= 1'h0;
		wr(MODE_OFS, 32'h0);
		wr(IRQ_CFG_OFS, 32'hFF);
		pol = 1'h1;
		clr();
		pulse_evt();
		wr(MODE_OFS, 32'h8);
		tick(10);
		chk(n_irq, 32'h0);
		pulse_evt();
		tick(10);
		chk(n_irq, (60 + 19) / 20);
		for (int s = 0; s < 3; s++) begin
			wr(IRQ_CFG_OFS, {24'h0, s[1:0], s[1:0], s[1:0], 2'h3});
			for (int e = 0; e < 3; e++) begin
				clr();
				u_sie.setup();
				u_sie.send(uioc_ep_t'(e), UIOC_HS_ACK);
				u_sie.send(uioc_ep_t'(e), UIOC_HS_NAK);
				u_sie.send(uioc_ep_t'(e), UIOC_HS_NAK);
				if (e == 0) u_sie.send(UIOC_EP_OUT, UIOC_HS_NYET);
				tick(3);
				ex = 1 + (e == 0) + (s == 0 ? 2 : (s == 1 ? 0 : 1));
				chk(n_hs, ex);
			end
		end
		wr(IRQ_CFG_OFS, 32'h03);
		wr(MODE_OFS, 32'h0F);
		@(posedge clk);
		bus_rst <= 1'h1;
		@(posedge clk);
		bus_rst <= 1'h0;
		rd(IRQ_CFG_OFS, 32'hFF);
		rd(MODE_OFS, 32'h0B);
		chk({31'h0, pu}, 32'h1);
		clr();
		act <= 1'h0;
		tick(15);
		chk(n_sirq, 32'h0);
		tick(25);
		chk(n_sirq, 32'h1);
		vbus <= 1'h1;
		clr();
		tick(40);
		chk(n_sirq, 32'h0);
		chk({31'h0, pu}, 32'h1);
		rd(MODE_OFS, 32'h10B);
		act <= 1'h1;
		wr(MODE_OFS, 32'h0);
		tick(2);
		chk({31'h0, pu}, 32'h0);
		susp <= 1'h1;
		tick(4);
		chk({31'h0, spin}, 32'h1);
		wr(MODE_OFS, 32'h4);
		clr();
		rd(STATUS_OFS, 32'h0A);
		tick(3);
		chk(n_wake, 32'h1);
		tick(20);
		susp <= 1'h0;
		tick(4);
		chk({31'h0, spin}, 32'h0);
		wr(MODE_OFS, 32'h2);
		susp <= 1'h1;
		tick(4);
		chk({31'h0, spin}, 32'h0);
		clr();
		susp <= 1'h0;
		tick(20);
		chk(n_spin, 32'h8);
		test_done();
	end
endmodule
